// ---- pswd_map.svh ----
// Register offsets, field positions, keys, oscillator codes and timing figures of the power-save block
`ifndef PSWD_MAP_SVH
`define PSWD_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PSWD_ADDR_CLOCK_DIVIDER_CONTROL    4'h0
`define PSWD_ADDR_RSTCTL    4'h4
`define PSWD_ADDR_OSCCTL    4'h8
`define PSWD_ADDR_MODDIS    4'hC

// ----------------------------------------
// Clock divider register fields
// ----------------------------------------
`define PSWD_CD_RECOVER     15
`define PSWD_CD_RATIO_HI    14
`define PSWD_CD_RATIO_LO    12
`define PSWD_CD_DOZE_EN     11
`define PSWD_CD_MASK        16'hF800

// ----------------------------------------
// Reset control register fields
// ----------------------------------------
`define PSWD_RC_REG_STBY    8
`define PSWD_RC_SOFT_EN     5
`define PSWD_RC_WDT_FLAG    4
`define PSWD_RC_WIN_FAULT   3
`define PSWD_RC_IDLE_FLAG   2
`define PSWD_RC_SLEEP_FLAG  1
`define PSWD_RC_MASK        16'h013E

// ----------------------------------------
// Oscillator control register fields
// ----------------------------------------
`define PSWD_OC_NEW_HI      10
`define PSWD_OC_NEW_LO      8
`define PSWD_OC_CUR_HI      14
`define PSWD_OC_CUR_LO      12
`define PSWD_OC_GO          0

// ----------------------------------------
// Configuration word bits
// ----------------------------------------
`define PSWD_CW1_WDT_EN     7
`define PSWD_CW1_PRESCALE   4
`define PSWD_CW1_WINDOW_DISABLE     6
`define PSWD_CW2_CSW_DIS    7

// ----------------------------------------
// Unlock keys, oscillator codes, timing
// ----------------------------------------
`define PSWD_KEY_FIRST      8'h46
`define PSWD_KEY_SECOND     8'h57
`define PSWD_OSC_FRC        3'h0
`define PSWD_OSC_PRIMARY    3'h2
`define PSWD_PRE_LONG       7'h7F
`define PSWD_PRE_SHORT      7'h1F
`define PSWD_LOW_POWER_INTERNAL_RC_HZ        32000
`define PSWD_CLK_HZ         25000000

`endif

// ---- pswd_pkg.sv ----
// Types shared by the power-save and watchdog block
package pswd_pkg;
    typedef enum logic [1:0] {
        PSWD_RUN,
        PSWD_IDLE,
        PSWD_SLEEP
    } pswd_mode_t;

    typedef enum logic [1:0] {
        PSWD_UNLOCKED_NONE,
        PSWD_KEY1_SEEN,
        PSWD_OPEN
    } pswd_lock_t;
endpackage

// ---- pswd_top.sv ----
// Power-save control and watchdog timer with an AXI4-Lite register slave
// Function
// - Power-save operand 1 enters Idle, 0 Sleep
// - Idle-stop bit set halts peripheral in Idle
// - Enabled interrupt or reset ends Sleep/Idle
// - Watchdog wake restores previous clock source
// - Other wakes run fast RC until primary ready
// - Doze enable bit 11 slows CPU clock
// - Ratio bits 14:12 select 1:1 to 1:128
// - Recover bit 15: interrupt cancels doze
// - Module disable gates clocks, hides registers
// - Switch-disable config bit ignores clock switches
// - Regulator standby bit 8 retains RAM only
// - Config bit 7 enables the watchdog
// - Four-bit postscaler selects timeout period
// - Watchdog enable forces low-power RC on
// - Timeout in Sleep/Idle wakes without reset
// - Soft enable bit 5 starts watchdog
// - Clear instruction, Sleep, new frequency clear counter
// - Prescale bit 4 selects 1:128 or 1:32
// - Window-disable clear makes watchdog windowed
// - Software or fail-safe clock switch clears watchdog counter
// - Timeout sets flag bit 4
// - Switch done when current equals new
`timescale 1ns/1ps
`default_nettype none
`include "pswd_map.svh"

module pswd_top #(
    parameter int NPERIPH = 8,
    parameter int LOW_POWER_INTERNAL_RC_DIV = `PSWD_CLK_HZ / `PSWD_LOW_POWER_INTERNAL_RC_HZ
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU events
    input wire logic power_save_instruction,
    input wire logic power_save_operand,
    input wire logic watchdog_clear_instruction,
    input wire logic irq_pending,
    input wire logic fail_safe_monitor,
    input wire logic primary_ready,
    // Configuration words
    input wire logic [15:0] config_word_one,
    input wire logic [15:0] config_word_two,
    // Peripheral control
    input wire logic [NPERIPH-1:0] peripheral_idle_stop,
    // Status and clock control outputs
    output logic [1:0] cpu_mode,
    output logic cpu_clk_en,
    output logic [NPERIPH-1:0] periph_clk_en,
    output logic [NPERIPH-1:0] periph_visible,
    output logic [2:0] current_oscillator,
    output logic low_power_internal_rc,
    output logic regulator_standby,
    output logic device_reset_req
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] clock_divider_register_q;
    logic [15:0] reset_control_register_q;
    logic [NPERIPH-1:0] module_disable_q;
    logic [2:0] new_oscillator_select_q;
    logic oscillator_switch_go_q;
    logic [2:0] cur_osc_q;
    logic [2:0] saved_osc_q;
    pswd_pkg::pswd_mode_t mode_q;
    pswd_pkg::pswd_lock_t lock_q;
    logic [6:0] doze_cnt_q;
    logic [15:0] low_power_internal_rc_cnt_q;
    logic [6:0] pre_cnt_q;
    logic [17:0] post_cnt_q;
    logic rst_req_q;
    logic wr_fire, rd_fire, wdt_on, low_power_internal_rc_tick, pre_tick, timeout, early_clear;
    logic osc_switch, wdt_clear, wake_irq, aw_held, w_held;
    logic [3:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic [17:0] post_limit;

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    // Address and data accepted in either order, response after both
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b0;
            aw_q <= 4'h0;
            w_q <= 32'h0;
            ws_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_rresp = 2'h0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `PSWD_ADDR_CLOCK_DIVIDER_CONTROL: s_axi_rdata <= {16'h0, clock_divider_register_q};
                `PSWD_ADDR_RSTCTL: s_axi_rdata <= {16'h0, reset_control_register_q};
                `PSWD_ADDR_OSCCTL: s_axi_rdata <= {17'h0, cur_osc_q, 1'b0,
                    new_oscillator_select_q, 7'h0, oscillator_switch_go_q};
                `PSWD_ADDR_MODDIS: s_axi_rdata <= 32'(module_disable_q);
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Oscillator control unlock
    // ----------------------------------------
    // Two keys to the low byte open the register for the next write only
    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_q <= pswd_pkg::PSWD_UNLOCKED_NONE;
        end else if (wr_fire && aw_q == `PSWD_ADDR_OSCCTL) begin
            case (lock_q)
                pswd_pkg::PSWD_UNLOCKED_NONE:
                    lock_q <= (w_q[7:0] == `PSWD_KEY_FIRST) ? pswd_pkg::PSWD_KEY1_SEEN
                        : pswd_pkg::PSWD_UNLOCKED_NONE;
                pswd_pkg::PSWD_KEY1_SEEN:
                    lock_q <= (w_q[7:0] == `PSWD_KEY_SECOND) ? pswd_pkg::PSWD_OPEN
                        : pswd_pkg::PSWD_UNLOCKED_NONE;
                default: lock_q <= pswd_pkg::PSWD_UNLOCKED_NONE;
            endcase
        end else if (wr_fire) begin
            lock_q <= pswd_pkg::PSWD_UNLOCKED_NONE;
        end
    end

    // ----------------------------------------
    // Clock switching
    // ----------------------------------------
    assign osc_switch = oscillator_switch_go_q && (new_oscillator_select_q != cur_osc_q);

    always_ff @(posedge mclk) begin
        if (rst) begin
            new_oscillator_select_q <= `PSWD_OSC_FRC;
            oscillator_switch_go_q <= 1'b0;
            cur_osc_q <= `PSWD_OSC_FRC;
        end else begin
            if (wr_fire && aw_q == `PSWD_ADDR_OSCCTL && lock_q == pswd_pkg::PSWD_OPEN
                && !config_word_two[`PSWD_CW2_CSW_DIS]) begin
                if (ws_q[1]) begin
                    new_oscillator_select_q <= w_q[`PSWD_OC_NEW_HI:`PSWD_OC_NEW_LO];
                end
                if (ws_q[0]) begin
                    oscillator_switch_go_q <= w_q[`PSWD_OC_GO];
                end
            end else if (osc_switch) begin
                cur_osc_q <= new_oscillator_select_q;
                oscillator_switch_go_q <= 1'b0;
            end else if (oscillator_switch_go_q) begin
                oscillator_switch_go_q <= 1'b0;
            end
            if (fail_safe_monitor) begin
                cur_osc_q <= `PSWD_OSC_FRC;
            end else if (wake_irq && mode_q != pswd_pkg::PSWD_RUN && !timeout) begin
                cur_osc_q <= primary_ready ? saved_osc_q : `PSWD_OSC_FRC;
            end else if (timeout && mode_q != pswd_pkg::PSWD_RUN) begin
                cur_osc_q <= saved_osc_q;
            end else if (cur_osc_q == `PSWD_OSC_FRC && saved_osc_q == `PSWD_OSC_PRIMARY
                && primary_ready && mode_q == pswd_pkg::PSWD_RUN) begin
                cur_osc_q <= saved_osc_q;
            end
        end
    end
    assign current_oscillator = cur_osc_q;

    // ----------------------------------------
    // Power modes
    // ----------------------------------------
    assign wake_irq = irq_pending;

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= pswd_pkg::PSWD_RUN;
            saved_osc_q <= `PSWD_OSC_FRC;
        end else begin
            case (mode_q)
                pswd_pkg::PSWD_RUN: begin
                    if (power_save_instruction) begin
                        mode_q <= power_save_operand ? pswd_pkg::PSWD_IDLE
                            : pswd_pkg::PSWD_SLEEP;
                        saved_osc_q <= cur_osc_q;
                    end
                end
                pswd_pkg::PSWD_IDLE, pswd_pkg::PSWD_SLEEP: begin
                    if (wake_irq || timeout) begin
                        mode_q <= pswd_pkg::PSWD_RUN;
                    end
                end
                default: mode_q <= pswd_pkg::PSWD_RUN;
            endcase
        end
    end
    assign cpu_mode = mode_q;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            clock_divider_register_q <= 16'h0;
            module_disable_q <= '0;
        end else begin
            if (wr_fire && aw_q == `PSWD_ADDR_CLOCK_DIVIDER_CONTROL) begin
                clock_divider_register_q <= w_q[15:0] & `PSWD_CD_MASK;
            end else if (wake_irq && clock_divider_register_q[`PSWD_CD_RECOVER]) begin
                clock_divider_register_q[`PSWD_CD_DOZE_EN] <= 1'b0;
            end
            if (wr_fire && aw_q == `PSWD_ADDR_MODDIS) begin
                module_disable_q <= w_q[NPERIPH-1:0];
            end
        end
    end

    // Reset control: timeout flag set wins over a software clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_control_register_q <= 16'h0;
        end else begin
            if (wr_fire && aw_q == `PSWD_ADDR_RSTCTL) begin
                reset_control_register_q <= w_q[15:0] & `PSWD_RC_MASK;
            end
            if (timeout) begin
                reset_control_register_q[`PSWD_RC_WDT_FLAG] <= 1'b1;
            end
            if (early_clear) begin
                reset_control_register_q[`PSWD_RC_WIN_FAULT] <= 1'b1;
            end
            if (power_save_instruction && mode_q == pswd_pkg::PSWD_RUN) begin
                reset_control_register_q[`PSWD_RC_IDLE_FLAG] <= power_save_operand;
                reset_control_register_q[`PSWD_RC_SLEEP_FLAG] <= !power_save_operand;
            end
        end
    end
    assign regulator_standby = reset_control_register_q[`PSWD_RC_REG_STBY]
        && mode_q == pswd_pkg::PSWD_SLEEP;

    // ----------------------------------------
    // Doze and clock gating
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            doze_cnt_q <= 7'h0;
        end else begin
            doze_cnt_q <= doze_cnt_q + 7'h1;
        end
    end

    // Ratio n gives one CPU enable every 2**n clocks
    always_comb begin
        logic [6:0] m;
        m = 7'(({7'h0, 1'b1} << clock_divider_register_q[`PSWD_CD_RATIO_HI:`PSWD_CD_RATIO_LO])
            - 8'h1);
        if (mode_q != pswd_pkg::PSWD_RUN) begin
            cpu_clk_en = 1'b0;
        end else if (clock_divider_register_q[`PSWD_CD_DOZE_EN]) begin
            cpu_clk_en = (doze_cnt_q & m) == 7'h0;
        end else begin
            cpu_clk_en = 1'b1;
        end
    end

    // Per-peripheral gates
    always_comb begin
        for (int i = 0; i < NPERIPH; i++) begin
            periph_clk_en[i] = !module_disable_q[i] && mode_q != pswd_pkg::PSWD_SLEEP
                && !(mode_q == pswd_pkg::PSWD_IDLE && peripheral_idle_stop[i]);
            periph_visible[i] = !module_disable_q[i];
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    assign wdt_on = config_word_one[`PSWD_CW1_WDT_EN]
        || reset_control_register_q[`PSWD_RC_SOFT_EN];
    assign low_power_internal_rc = wdt_on;
    assign wdt_clear = watchdog_clear_instruction
        || (power_save_instruction && mode_q == pswd_pkg::PSWD_RUN)
        || osc_switch || fail_safe_monitor;
    assign low_power_internal_rc_tick = low_power_internal_rc_cnt_q == 16'(LOW_POWER_INTERNAL_RC_DIV - 1);
    assign pre_tick = low_power_internal_rc_tick && pre_cnt_q == (config_word_one[`PSWD_CW1_PRESCALE]
        ? `PSWD_PRE_LONG : `PSWD_PRE_SHORT);
    assign post_limit = 18'h1 << config_word_one[3:0];
    assign timeout = wdt_on && pre_tick && post_cnt_q == post_limit - 18'h1;
    assign early_clear = wdt_on && watchdog_clear_instruction
        && !config_word_one[`PSWD_CW1_WINDOW_DISABLE]
        && post_cnt_q < (post_limit - (post_limit >> 2));

    always_ff @(posedge mclk) begin
        if (rst || !wdt_on || wdt_clear) begin
            low_power_internal_rc_cnt_q <= 16'h0;
            pre_cnt_q <= 7'h0;
            post_cnt_q <= 18'h0;
        end else begin
            low_power_internal_rc_cnt_q <= low_power_internal_rc_tick ? 16'h0 : low_power_internal_rc_cnt_q + 16'h1;
            if (low_power_internal_rc_tick) begin
                pre_cnt_q <= pre_tick ? 7'h0 : pre_cnt_q + 7'h1;
            end
            if (pre_tick) begin
                post_cnt_q <= timeout ? 18'h0 : post_cnt_q + 18'h1;
            end
        end
    end

    // Device reset request on running timeout or early clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            rst_req_q <= 1'b0;
        end else begin
            rst_req_q <= (timeout && mode_q == pswd_pkg::PSWD_RUN) || early_clear;
        end
    end
    assign device_reset_req = rst_req_q;

endmodule
`default_nettype wire

// ---- pswd_top_monitor.sv ----
// Assertion checker for the power-save and watchdog block
`timescale 1ns/1ps
`default_nettype none
module pswd_top_monitor #(
    parameter int NPERIPH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Events and status
    input wire logic power_save_instruction,
    input wire logic power_save_operand,
    input wire logic irq_pending,
    input wire logic fail_safe_monitor,
    input wire logic [15:0] config_word_one,
    input wire logic [NPERIPH-1:0] peripheral_idle_stop,
    input wire logic [1:0] cpu_mode,
    input wire logic cpu_clk_en,
    input wire logic [NPERIPH-1:0] periph_clk_en,
    input wire logic [NPERIPH-1:0] periph_visible,
    input wire logic [2:0] current_oscillator,
    input wire logic low_power_internal_rc,
    input wire logic regulator_standby
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_idle_entry: assert property (cpu_mode == 2'h0 && power_save_instruction
        && power_save_operand && !irq_pending |=> cpu_mode == 2'h1) else $error("no idle");
    a_sleep_entry: assert property (cpu_mode == 2'h0 && power_save_instruction
        && !power_save_operand && !irq_pending |=> cpu_mode == 2'h2) else $error("no sleep");
    a_irq_wake: assert property (cpu_mode != 2'h0 && irq_pending
        |-> ##[1:2] cpu_mode == 2'h0) else $error("no irq wake");
    a_cpu_halted: assert property (cpu_mode != 2'h0 |-> !cpu_clk_en)
        else $error("cpu clock on");
    a_idle_stop: assert property (cpu_mode == 2'h1
        |-> periph_clk_en == (periph_visible & ~peripheral_idle_stop)) else $error("idle gating");
    a_run_periph: assert property (cpu_mode == 2'h0 |-> periph_clk_en == periph_visible)
        else $error("run gating");
    a_wdt_low_power_internal_rc: assert property (config_word_one[7] |-> low_power_internal_rc)
        else $error("low_power_internal_rc off");
    a_stby_sleep: assert property (regulator_standby |-> cpu_mode == 2'h2)
        else $error("standby awake");
    a_failsafe_frc: assert property ($rose(fail_safe_monitor)
        |-> ##[1:4] current_oscillator == 3'h0) else $error("no fail-safe");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write dropped");
endmodule
bind pswd_top pswd_top_monitor #(.NPERIPH(NPERIPH)) u_mon (.*);
`default_nettype wire

// ---- power_save_and_watchdog_tb.sv ----
// Self-checking bench for the power-save and watchdog block
`timescale 1ns/1ps
`default_nettype none
module power_save_and_watchdog_tb;
    localparam int DIV = 4;
    logic mclk = 1'h0, rst = 1'h1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, cpu_mode;
    logic power_save_instruction = 1'h0, power_save_operand = 1'h0;
    logic watchdog_clear_instruction = 1'h0, irq_pending = 1'h0;
    logic fail_safe_monitor = 1'h0, primary_ready = 1'h1;
    logic [15:0] config_word_one = 16'h0, config_word_two = 16'h0;
    logic [7:0] peripheral_idle_stop = 8'h0, periph_clk_en, periph_visible, m;
    logic [2:0] current_oscillator;
    logic cpu_clk_en, low_power_internal_rc, regulator_standby, device_reset_req;
    int error_cnt = 0, compares = 0, cyc = 0, t, n;

    pswd_top #(.NPERIPH(8), .LOW_POWER_INTERNAL_RC_DIV(DIV)) uut (.*);

    // Clock and hang guard
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (++cyc == 60000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("%0d compares %0d errors", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Write, aw and w together
    task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
        logic got;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        got = 1'h0;
        while (!got) begin
            @(posedge mclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            got = (s_axi_bvalid === 1'h1);
        end
        s_axi_bready <= 1'h0;
    endtask
    task automatic axr(input logic [3:0] a);
        logic got;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        got = 1'h0;
        while (!got) begin
            @(posedge mclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            got = (s_axi_rvalid === 1'h1);
            d = s_axi_rdata;
        end
        s_axi_rready <= 1'h0;
    endtask
    task automatic pwr(input logic op);
        @(posedge mclk);
        power_save_operand <= op;
        power_save_instruction <= 1'h1;
        @(posedge mclk);
        power_save_instruction <= 1'h0;
    endtask
    // Wait for a mode, count resets
    task automatic wait_mode(input logic [1:0] md);
        n = 0;
        t = 0;
        while (cpu_mode !== md && t < 2000) begin
            @(posedge mclk);
            t++;
            n += (device_reset_req === 1'h1);
        end
    endtask
    task automatic osc_sw(input logic [2:0] c);
        axw(4'h8, 32'h46, 4'h1);
        axw(4'h8, 32'h57, 4'h1);
        axw(4'h8, {21'h0, c, 8'h01}, 4'h3);
    endtask
    task automatic clr;
        @(posedge mclk);
        watchdog_clear_instruction <= 1'h1;
        @(posedge mclk);
        watchdog_clear_instruction <= 1'h0;
    endtask
    // Cycles from clear to reset
    task automatic wd_time;
        clr();
        t = 0;
        while (device_reset_req !== 1'h1 && t < 9000) begin
            @(posedge mclk);
            t++;
        end
    endtask
    task automatic count_cpu;
        repeat (4) @(posedge mclk);
        n = 0;
        repeat (128) begin
            @(posedge mclk);
            n += (cpu_clk_en === 1'h1);
        end
    endtask
    task automatic wd_chk(input logic pre, input int ps);
        int pc, p;
        pc = pre ? 128 : 32;
        p = DIV * pc * (1 << ps);
        config_word_one <= {8'h0, 2'h3, 1'h0, pre, ps[3:0]};
        wd_time();
        chk("wdt period", (t >= p - DIV * pc - 8) && (t <= p + 8), 1);
    endtask
    initial begin
        t = $urandom(32'h88B4);
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            axr(4'(i * 4));
            chk("reset value", d, 32'h0);
        end
        repeat (4) begin
            n = $urandom;
            axw(4'h0, n, 4'hF);
            axr(4'h0);
            chk("divider", d, n & 32'hF800);
        end
        axr(4'h2);
        chk("unmapped", d, 32'h0);
        $display("test registers finished");
        // Doze and recovery
        for (int r = 0; r < 8; r++) begin
            axw(4'h0, 32'h0800 | (r << 12), 4'h3);
            count_cpu();
            chk("doze clocks", n, 128 >> r);
        end
        axw(4'h0, 32'h7000, 4'h3);
        count_cpu();
        chk("doze off", n, 128);
        axw(4'h0, 32'hF800, 4'h3);
        irq_pending <= 1'h1;
        count_cpu();
        chk("recover", n, 128);
        irq_pending <= 1'h0;
        axw(4'h0, 32'h0, 4'h3);
        $display("test doze finished");
        // Module disable and idle stop
        m = $urandom;
        peripheral_idle_stop <= $urandom;
        axw(4'hC, {24'h0, m}, 4'h3);
        chk("visible", periph_visible, 8'(~m));
        pwr(1'h1);
        wait_mode(2'h1);
        chk("idle mode", cpu_mode, 2'h1);
        chk("idle clocks", periph_clk_en, 8'(~m & ~peripheral_idle_stop));
        chk("cpu halted", cpu_clk_en, 1'h0);
        irq_pending <= 1'h1;
        wait_mode(2'h0);
        chk("wake", cpu_mode, 2'h0);
        irq_pending <= 1'h0;
        axw(4'hC, 32'h0, 4'h3);
        $display("test idle finished");
        // Clock switching
        osc_sw(3'h2);
        repeat (4) @(posedge mclk);
        axr(4'h8);
        chk("switch done", d[14:12], 3'h2);
        axw(4'h8, 32'h0001, 4'h3);
        repeat (50) @(posedge mclk);
        chk("locked", current_oscillator, 3'h2);
        config_word_two <= 16'h0080;
        osc_sw(3'h0);
        repeat (50) @(posedge mclk);
        chk("switch off", current_oscillator, 3'h2);
        config_word_two <= 16'h0;
        fail_safe_monitor <= 1'h1;
        @(posedge mclk);
        fail_safe_monitor <= 1'h0;
        repeat (8) @(posedge mclk);
        chk("fail-safe", current_oscillator, 3'h0);
        // Sleep, standby, slow wake
        osc_sw(3'h2);
        repeat (20) @(posedge mclk);
        axw(4'h4, 32'h0100, 4'h3);
        primary_ready <= 1'h0;
        pwr(1'h0);
        wait_mode(2'h2);
        chk("standby", regulator_standby, 1'h1);
        irq_pending <= 1'h1;
        wait_mode(2'h0);
        irq_pending <= 1'h0;
        repeat (4) @(posedge mclk);
        chk("wake source", current_oscillator, 3'h0);
        chk("standby off", regulator_standby, 1'h0);
        primary_ready <= 1'h1;
        axw(4'h4, 32'h0, 4'h3);
        $display("test clocks finished");
        // Watchdog periods
        repeat (4) wd_chk($urandom % 2, $urandom % 3);
        wd_chk(1'h1, 2);
        axr(4'h4);
        chk("timeout flag", d[4], 1'h1);
        config_word_one <= 16'h0;
        axw(4'h4, 32'h0, 4'h3);
        axr(4'h4);
        chk("flag cleared", d[4], 1'h0);
        config_word_one <= 16'h00C2;
        n = 0;
        repeat (8) begin
            clr();
            repeat (100) begin
                @(posedge mclk);
                n += (device_reset_req === 1'h1);
            end
        end
        chk("kept alive", n, 0);
        // Sleep timeout wake
        osc_sw(3'h2);
        config_word_one <= 16'h00C0;
        repeat (20) @(posedge mclk);
        primary_ready <= 1'h0;
        pwr(1'h0);
        wait_mode(2'h2);
        wait_mode(2'h0);
        chk("wdt wake", cpu_mode, 2'h0);
        chk("no reset", n, 0);
        chk("restored", current_oscillator, 3'h2);
        primary_ready <= 1'h1;
        // Early clear in window mode
        config_word_one <= 16'h0080;
        clr();
        repeat (5) @(posedge mclk);
        wd_time();
        chk("early clear", t < 10, 1);
        axr(4'h4);
        chk("window fault", d[3], 1'h1);
        // Software enable
        config_word_one <= 16'h0040;
        axw(4'h4, 32'h0, 4'h3);
        repeat (4) @(posedge mclk);
        chk("wdt off", low_power_internal_rc, 1'h0);
        axw(4'h4, 32'h0020, 4'h3);
        chk("soft enable", low_power_internal_rc, 1'h1);
        wd_time();
        chk("soft timeout", (t >= DIV * 32 - 8) && (t <= DIV * 32 + 8), 1);
        $display("test watchdog finished");
        end_of_test();
    end
endmodule
`default_nettype wire
